// >>> design/acc_defs.svh
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
// What this block does
// - Ratio field zero: detect reference-to-frame-sync ratio automatically.
// - Ratio field 1 to 16383: use the programmed ratio directly.
// - Ratio is six high bits from one register plus eight low bits.
// - Three-bit reference frequency select, 12 to 24.576 MHz, resets to code 1.
// - Bit 4 sets primary port target (0) or controller (1).
// - Bit 3 sets secondary port target (0) or controller (1), resets target.
// - Family bit: 0 for 48 kHz rates, 1 for 44.1 kHz, both ports.
// - Reserved bits read zero; software writes only zero there.
// - Bit 7 picks external (0) or internal (1) bit clock for frame sync.
// - Bit 6 inverts bit clock only for frame sync generation.
// - Bits 5 to 0 hold high six bits of primary frame ratio.
// - Separate byte register holds low eight bits of primary frame ratio.

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACC_ADDR_RATIO_HI   8'h35
`define ACC_ADDR_RATIO_LO   8'h36
`define ACC_ADDR_MODE       8'h37
`define ACC_ADDR_FGEN       8'h38
`define ACC_ADDR_FRATIO_LO  8'h39
`define ACC_ADDR_DET_HI     8'h70
`define ACC_ADDR_DET_LO     8'h71

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACC_RST_MODE        8'h20
`define ACC_RST_ZERO        8'h00
`define ACC_RST_FREQ        3'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACC_FREQ_MSB        7
`define ACC_FREQ_LSB        5
`define ACC_PRI_BIT         4
`define ACC_SEC_BIT         3
`define ACC_FAM_BIT         0
`define ACC_INT_BIT         7
`define ACC_INV_BIT         6
`define ACC_HI_MSB          5
`define ACC_DET_VALID_BIT   7

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ACC_RATIO_MAX       14'h3FFF
`define ACC_BCLK_HALF       4'h4
`endif

// >>> design/acc_pkg.sv
package acc_pkg;
    typedef logic [13:0] acc_ratio_t;

    typedef enum logic [1:0]
    {
        ACC_DET_WAIT  = 2'b01,
        ACC_DET_COUNT = 2'b10
    } acc_det_state_t;

    typedef struct packed {
        acc_ratio_t cnt;
        logic       fsync;
    } acc_fgen_state_t;
endpackage : acc_pkg

// >>> design/acc_fgen_if.sv
interface acc_fgen_if;
    import acc_pkg::*;
    logic       tick;
    logic       en;
    acc_ratio_t ratio;
    logic       fsync;
    modport gen (input tick, input en, input ratio, output fsync);
    modport ctl (output tick, output en, output ratio, input fsync);
endinterface : acc_fgen_if

// >>> design/acc_frame_gen.sv
module acc_frame_gen
    import acc_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    acc_fgen_if.gen     fg
);
    acc_fgen_state_t st_reg;
    acc_fgen_state_t st_next;

    // ----------------------------------------
    // Frame counter
    // ----------------------------------------
    always_comb
    begin
        st_next = st_reg;
        if (!fg.en)
        begin
            st_next.cnt   = '0;
            st_next.fsync = 1'b0;
        end
        else if (fg.tick)
        begin
            st_next.fsync = (st_reg.cnt == '0);
            if (st_reg.cnt >= acc_ratio_t'(fg.ratio - 14'h0001))
            begin
                st_next.cnt = '0;
            end
            else
            begin
                st_next.cnt = acc_ratio_t'(st_reg.cnt + 14'h0001);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign fg.fsync = st_reg.fsync;
endmodule : acc_frame_gen

// >>> design/acc_clock_config.sv
`include "acc_defs.svh"

module acc_clock_config
    import acc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        cclk_i,
    input  wire logic        pbclk_i,
    output logic             pbclk_o,
    output logic             pbclk_oe_o,
    input  wire logic        pfsync_i,
    output logic             pfsync_o,
    output logic             pfsync_oe_o,
    output logic             secondary_port_role_select_o,
    output logic      [2:0]  refclk_frequency_select_o,
    output logic             sample_rate_family_select_o,
    output acc_ratio_t       refclk_ratio_o,
    output logic             refclk_ratio_auto_o
);

    // ----------------------------------------
    // State types
    // ----------------------------------------
    typedef struct packed {
        logic [5:0]     ratio_hi;
        logic [7:0]     ratio_lo;
        logic [2:0]     freq_sel;
        logic           pri_ctl;
        logic           sec_ctl;
        logic           family;
        logic           fr_int;
        logic           fr_inv;
        logic [5:0]     fr_hi;
        logic [7:0]     fr_lo;
        logic [7:0]     rdata;
        logic           cclk_s1;
        logic           cclk_s2;
        logic           cclk_prev;
        logic           fs_s1;
        logic           fs_s2;
        logic           fs_prev;
        acc_det_state_t det_state;
        acc_ratio_t     det_cnt;
        acc_ratio_t     det_ratio;
        logic           det_valid;
        logic [3:0]     bclk_div;
        logic           bclk_int;
        logic           bclk_prev;
        logic [15:0]    xfer_word;
        logic           req_tgl;
        logic           ack_s1;
        logic           ack_s2;
        acc_ratio_t     ratio_eff;
    } acc_ref_state_t;

    typedef struct packed {
        logic       rst_s1;
        logic       rst_s2;
        logic       req_s1;
        logic       req_s2;
        logic       ack_tgl;
        logic       cfg_inv;
        logic       cfg_en;
        acc_ratio_t cfg_ratio;
    } acc_link_state_t;

    acc_ref_state_t  ref_reg;
    acc_ref_state_t  ref_next;
    acc_link_state_t lnk_reg;
    acc_link_state_t lnk_next;
    logic            fs_neg_reg;
    logic            cclk_rise;
    logic            fs_rise;
    logic            int_tick;
    logic            link_fsync;
    acc_ratio_t      ref_field;
    acc_ratio_t      frame_ratio;
    logic [15:0]     cfg_word;

    acc_fgen_if      fg_int ();
    acc_fgen_if      fg_ext ();

    // ----------------------------------------
    // Register read decode
    // ----------------------------------------
    function automatic logic [7:0] acc_read(input logic [7:0] addr, input acc_ref_state_t s);
        logic [7:0] d;
        d = 8'h00;
        case (addr)
            `ACC_ADDR_RATIO_HI:
            begin
                d = {2'b00, s.ratio_hi};
            end
            `ACC_ADDR_RATIO_LO:
            begin
                d = s.ratio_lo;
            end
            `ACC_ADDR_MODE:
            begin
                d = {s.freq_sel, s.pri_ctl, s.sec_ctl, 2'b00, s.family};
            end
            `ACC_ADDR_FGEN:
            begin
                d = {s.fr_int, s.fr_inv, s.fr_hi};
            end
            `ACC_ADDR_FRATIO_LO:
            begin
                d = s.fr_lo;
            end
            `ACC_ADDR_DET_HI:
            begin
                d = {s.det_valid, 1'b0, s.det_ratio[13:8]};
            end
            `ACC_ADDR_DET_LO:
            begin
                d = s.det_ratio[7:0];
            end
            default:
            begin
                d = 8'h00;
            end
        endcase
        return d;
    endfunction : acc_read

    // ----------------------------------------
    // Derived terms
    // ----------------------------------------
    assign ref_field   = {ref_reg.ratio_hi, ref_reg.ratio_lo};
    assign frame_ratio = {ref_reg.fr_hi, ref_reg.fr_lo};
    assign cclk_rise   = ref_reg.cclk_s2 & ~ref_reg.cclk_prev;
    assign fs_rise     = ref_reg.fs_s2 & ~ref_reg.fs_prev;
    assign int_tick    = ref_reg.fr_inv ? (ref_reg.bclk_prev & ~ref_reg.bclk_int)
                                        : (~ref_reg.bclk_prev & ref_reg.bclk_int);
    assign cfg_word    = {ref_reg.fr_inv,
                          ref_reg.pri_ctl & ~ref_reg.fr_int & (frame_ratio != '0),
                          frame_ratio};

    // ----------------------------------------
    // Reference domain next state
    // ----------------------------------------
    always_comb
    begin
        ref_next = ref_reg;

        ref_next.cclk_s1   = cclk_i;
        ref_next.cclk_s2   = ref_reg.cclk_s1;
        ref_next.cclk_prev = ref_reg.cclk_s2;
        ref_next.fs_s1     = pfsync_i;
        ref_next.fs_s2     = ref_reg.fs_s1;
        ref_next.fs_prev   = ref_reg.fs_s2;
        ref_next.ack_s1    = lnk_reg.ack_tgl;
        ref_next.ack_s2    = ref_reg.ack_s1;

        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `ACC_ADDR_RATIO_HI:
                begin
                    ref_next.ratio_hi = reg_wdata_i[`ACC_HI_MSB:0];
                end
                `ACC_ADDR_RATIO_LO:
                begin
                    ref_next.ratio_lo = reg_wdata_i;
                end
                `ACC_ADDR_MODE:
                begin
                    ref_next.freq_sel = reg_wdata_i[`ACC_FREQ_MSB:`ACC_FREQ_LSB];
                    ref_next.pri_ctl  = reg_wdata_i[`ACC_PRI_BIT];
                    ref_next.sec_ctl  = reg_wdata_i[`ACC_SEC_BIT];
                    ref_next.family   = reg_wdata_i[`ACC_FAM_BIT];
                end
                `ACC_ADDR_FGEN:
                begin
                    ref_next.fr_int = reg_wdata_i[`ACC_INT_BIT];
                    ref_next.fr_inv = reg_wdata_i[`ACC_INV_BIT];
                    ref_next.fr_hi  = reg_wdata_i[`ACC_HI_MSB:0];
                end
                `ACC_ADDR_FRATIO_LO:
                begin
                    ref_next.fr_lo = reg_wdata_i;
                end
                default:
                begin
                    ref_next.fr_lo = ref_reg.fr_lo;
                end
            endcase
        end

        if (reg_rd_i)
        begin
            ref_next.rdata = acc_read(reg_addr_i, ref_reg);
        end

        // Ratio detection against the frame sync line
        case (ref_reg.det_state)
            ACC_DET_WAIT:
            begin
                ref_next.det_cnt = '0;
                if (fs_rise && (ref_field == '0))
                begin
                    ref_next.det_state = ACC_DET_COUNT;
                end
            end
            ACC_DET_COUNT:
            begin
                if (ref_field != '0)
                begin
                    ref_next.det_state = ACC_DET_WAIT;
                end
                else if (fs_rise)
                begin
                    ref_next.det_ratio = ref_reg.det_cnt;
                    ref_next.det_valid = 1'b1;
                    ref_next.det_cnt   = cclk_rise ? 14'h0001 : 14'h0000;
                end
                else if (cclk_rise && (ref_reg.det_cnt != `ACC_RATIO_MAX))
                begin
                    ref_next.det_cnt = acc_ratio_t'(ref_reg.det_cnt + 14'h0001);
                end
            end
            default:
            begin
                ref_next.det_state = ACC_DET_WAIT;
            end
        endcase

        ref_next.ratio_eff = (ref_field == '0) ? ref_reg.det_ratio : ref_field;

        // Internal bit clock, stopped while the port is a target
        ref_next.bclk_prev = ref_reg.bclk_int;
        if (!(ref_reg.pri_ctl && ref_reg.fr_int))
        begin
            ref_next.bclk_div = 4'h0;
            ref_next.bclk_int = 1'b0;
        end
        else if (ref_reg.bclk_div == `ACC_BCLK_HALF - 4'h1)
        begin
            ref_next.bclk_div = 4'h0;
            ref_next.bclk_int = ~ref_reg.bclk_int;
        end
        else
        begin
            ref_next.bclk_div = ref_reg.bclk_div + 4'h1;
        end

        // Toggle handshake carrying settings to the link side
        if ((ref_reg.ack_s2 == ref_reg.req_tgl) && (ref_reg.xfer_word != cfg_word))
        begin
            ref_next.xfer_word = cfg_word;
            ref_next.req_tgl   = ~ref_reg.req_tgl;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ref_reg           <= '0;
            ref_reg.freq_sel  <= `ACC_RST_FREQ;
            ref_reg.det_state <= ACC_DET_WAIT;
        end
        else
        begin
            ref_reg <= ref_next;
        end
    end

    // ----------------------------------------
    // Link domain next state
    // ----------------------------------------
    always_comb
    begin
        lnk_next        = lnk_reg;
        lnk_next.rst_s1 = sys_rst_i;
        lnk_next.rst_s2 = lnk_reg.rst_s1;
        lnk_next.req_s1 = ref_reg.req_tgl;
        lnk_next.req_s2 = lnk_reg.req_s1;
        if (lnk_reg.rst_s2)
        begin
            lnk_next.ack_tgl   = 1'b0;
            lnk_next.cfg_inv   = 1'b0;
            lnk_next.cfg_en    = 1'b0;
            lnk_next.cfg_ratio = '0;
        end
        else if (lnk_reg.req_s2 != lnk_reg.ack_tgl)
        begin
            lnk_next.cfg_inv   = ref_reg.xfer_word[15];
            lnk_next.cfg_en    = ref_reg.xfer_word[14];
            lnk_next.cfg_ratio = ref_reg.xfer_word[13:0];
            lnk_next.ack_tgl   = lnk_reg.req_s2;
        end
    end

    always_ff @(posedge pbclk_i)
    begin
        lnk_reg <= lnk_next;
    end

    // Falling-edge launch of frame sync when the bit clock is inverted
    always_ff @(negedge pbclk_i)
    begin
        fs_neg_reg <= fg_ext.fsync;
    end

    // ----------------------------------------
    // Frame generators
    // ----------------------------------------
    assign fg_int.tick  = int_tick;
    assign fg_int.en    = ref_reg.pri_ctl & ref_reg.fr_int & (frame_ratio != '0);
    assign fg_int.ratio = frame_ratio;

    assign fg_ext.tick  = 1'b1;
    assign fg_ext.en    = lnk_reg.cfg_en;
    assign fg_ext.ratio = lnk_reg.cfg_ratio;

    acc_frame_gen u_fgen_int
    (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .fg    (fg_int.gen)
    );

    acc_frame_gen u_fgen_ext
    (
        .clk_i (pbclk_i),
        .rst_i (lnk_reg.rst_s2),
        .fg    (fg_ext.gen)
    );

    assign link_fsync = lnk_reg.cfg_inv ? fs_neg_reg : fg_ext.fsync;

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_o                  = ref_reg.rdata;
    assign pbclk_o                      = ref_reg.bclk_int;
    assign pbclk_oe_o                   = ref_reg.pri_ctl & ref_reg.fr_int;
    assign pfsync_o                     = ref_reg.pri_ctl &
                                          (ref_reg.fr_int ? fg_int.fsync : link_fsync);
    assign pfsync_oe_o                  = ref_reg.pri_ctl;
    assign secondary_port_role_select_o = ref_reg.sec_ctl;
    assign refclk_frequency_select_o    = ref_reg.freq_sel;
    assign sample_rate_family_select_o  = ref_reg.family;
    assign refclk_ratio_o               = ref_reg.ratio_eff;
    assign refclk_ratio_auto_o          = (ref_field == '0);
endmodule : acc_clock_config

// >>> test/acc_clock_config_chk.sv
module acc_clock_config_chk
(
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       pbclk_o,
    input wire logic       pbclk_oe_o,
    input wire logic       pfsync_o,
    input wire logic       pfsync_oe_o,
    input wire logic       secondary_port_role_select_o,
    input wire logic [2:0] refclk_frequency_select_o,
    input wire logic       sample_rate_family_select_o,
    input wire logic       refclk_ratio_auto_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    logic wr_mode;
    assign wr_mode = reg_wr_i && (reg_addr_i == 8'h37);

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence half_hold;
        (!pbclk_oe_o || $stable(pbclk_o)) [*3];
    endsequence
    sequence half_flip;
        !pbclk_oe_o || $changed(pbclk_o);
    endsequence
    sequence fs_high;
        (pfsync_o || !pbclk_oe_o) [*8];
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_freq_write: assert property (wr_mode |=>
        refclk_frequency_select_o == $past(reg_wdata_i[7:5])) else $error("freq select");
    chk_pri_role: assert property (wr_mode |=>
        pfsync_oe_o == $past(reg_wdata_i[4])) else $error("primary role");
    chk_sec_role: assert property (wr_mode |=>
        secondary_port_role_select_o == $past(reg_wdata_i[3])) else $error("secondary role");
    chk_family_write: assert property (wr_mode |=>
        sample_rate_family_select_o == $past(reg_wdata_i[0])) else $error("family");
    chk_mode_readback: assert property (reg_rd_i && reg_addr_i == 8'h37 |=>
        reg_rdata_o == {$past(refclk_frequency_select_o), $past(pfsync_oe_o),
        $past(secondary_port_role_select_o), 2'b00, $past(sample_rate_family_select_o)})
        else $error("mode readback");
    chk_ratio_manual: assert property (reg_wr_i && reg_addr_i == 8'h36
        && reg_wdata_i != 8'h00 |=> !refclk_ratio_auto_o) else $error("ratio auto flag");
    chk_target_idle: assert property (!pfsync_oe_o |-> !pbclk_oe_o)
        else $error("bit clock driven in target");
    chk_bclk_half: assert property ($changed(pbclk_o) && pbclk_oe_o && $past(pbclk_oe_o)
        |=> half_hold ##1 half_flip) else $error("bit clock half period");
    chk_fsync_width: assert property ($rose(pfsync_o) && pbclk_oe_o
        |-> fs_high ##1 (!pfsync_o || !pbclk_oe_o)) else $error("frame sync width");
endmodule : acc_clock_config_chk

bind acc_clock_config acc_clock_config_chk acc_clock_config_chk_inst (
    .ref_clk_i                    (ref_clk_i),
    .sys_rst_i                    (sys_rst_i),
    .reg_addr_i                   (reg_addr_i),
    .reg_wdata_i                  (reg_wdata_i),
    .reg_wr_i                     (reg_wr_i),
    .reg_rd_i                     (reg_rd_i),
    .reg_rdata_o                  (reg_rdata_o),
    .pbclk_o                      (pbclk_o),
    .pbclk_oe_o                   (pbclk_oe_o),
    .pfsync_o                     (pfsync_o),
    .pfsync_oe_o                  (pfsync_oe_o),
    .secondary_port_role_select_o (secondary_port_role_select_o),
    .refclk_frequency_select_o    (refclk_frequency_select_o),
    .sample_rate_family_select_o  (sample_rate_family_select_o),
    .refclk_ratio_auto_o          (refclk_ratio_auto_o)
);

// >>> test/acc_host_model.sv
module acc_host_model
#(
    parameter int FRAME = 8
)
(
    input  wire logic run_i,
    output logic      bclk_o,
    output logic      fsync_o,
    output logic      cclk_o
);
    timeunit 1ns;
    timeprecision 100ps;

    int   cnt = 0;
    logic clk = 1'b0;

    // Bit clock stands still while the device drives it
    initial
    begin
        #1;
        forever #15 clk = ~clk;
    end
    assign bclk_o = run_i & clk;
    assign cclk_o = bclk_o;

    initial fsync_o = 1'b0;
    always @(negedge clk)
    begin
        cnt     <= (cnt + 1) % FRAME;
        fsync_o <= run_i && (cnt == 0);
    end
endmodule : acc_host_model

// >>> test/tb_top.sv
module tb_top
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       ref_clk_i;
    logic       sys_rst_i;
    logic       reg_wr_i;
    logic       reg_rd_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic       pbclk_o;
    logic       pbclk_oe_o;
    logic       pfsync_o;
    logic       pfsync_oe_o;
    logic       sec_o;
    logic       fam_o;
    logic       auto_o;
    logic [2:0] freq_o;
    acc_ratio_t ratio_o;
    logic       h_bclk;
    logic       h_fsync;
    logic       h_cclk;
    logic       bclk_w;
    logic       fsync_w;
    int         n_errors = 0;
    int         tests_run = 0;

    // Pin levels from all drivers
    assign bclk_w  = pbclk_oe_o ? pbclk_o : h_bclk;
    assign fsync_w = pfsync_oe_o ? pfsync_o : h_fsync;

    acc_host_model acc_host_model_inst (
        .run_i   (!pbclk_oe_o),
        .bclk_o  (h_bclk),
        .fsync_o (h_fsync),
        .cclk_o  (h_cclk)
    );

    acc_clock_config acc_clock_config_inst (
        .ref_clk_i                    (ref_clk_i),
        .sys_rst_i                    (sys_rst_i),
        .reg_addr_i                   (reg_addr_i),
        .reg_wdata_i                  (reg_wdata_i),
        .reg_wr_i                     (reg_wr_i),
        .reg_rd_i                     (reg_rd_i),
        .reg_rdata_o                  (reg_rdata_o),
        .cclk_i                       (h_cclk),
        .pbclk_i                      (bclk_w),
        .pbclk_o                      (pbclk_o),
        .pbclk_oe_o                   (pbclk_oe_o),
        .pfsync_i                     (fsync_w),
        .pfsync_o                     (pfsync_o),
        .pfsync_oe_o                  (pfsync_oe_o),
        .secondary_port_role_select_o (sec_o),
        .refclk_frequency_select_o    (freq_o),
        .sample_rate_family_select_o  (fam_o),
        .refclk_ratio_o               (ratio_o),
        .refclk_ratio_auto_o          (auto_o)
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test;
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
        @(negedge ref_clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        @(negedge ref_clk_i);
        chk("read data", e, reg_rdata_o);
    endtask : rd

    task automatic rise(output int c);
        c = 0;
        while (pfsync_o !== 1'b0 && c < 5000)
        begin
            @(negedge ref_clk_i);
            c++;
        end
        while (pfsync_o !== 1'b1 && c < 5000)
        begin
            @(negedge ref_clk_i);
            c++;
        end
    endtask : rise

    task automatic frame(input logic [7:0] f, input logic [7:0] l, input int e);
        int n;
        wr(8'h37, 8'h20);
        wr(8'h38, f);
        wr(8'h39, l);
        wr(8'h37, 8'h30);
        chk("bit clock enable", f[7], pbclk_oe_o);
        rise(n);
        rise(n);
        chk("frame period", e, n);
        wr(8'h37, 8'h20);
        repeat (60) @(negedge ref_clk_i);
        chk("target frame sync", 1'b0, pfsync_o);
    endtask : frame

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (40000) @(posedge ref_clk_i);
        n_errors++;
        stop_test;
    end

    initial
    begin
        sys_rst_i   = 1'b1;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        reg_addr_i  = 8'h00;
        reg_wdata_i = 8'h00;
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(8'h37, 8'h20);
        for (int a = 8'h35; a <= 8'h39; a++)
            if (a != 8'h37)
                rd(a[7:0], 8'h00);
        wr(8'h37, 8'hF9);
        rd(8'h37, 8'hF9);
        chk("secondary role", 1'b1, sec_o);
        chk("family", 1'b1, fam_o);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h37, {i[2:0], 5'h00});
            chk("freq select", i[2:0], freq_o);
        end
        wr(8'h50, 8'hAA);
        rd(8'h50, 8'h00);
        wr(8'h38, 8'hC5);
        rd(8'h38, 8'hC5);
        wr(8'h39, 8'hA3);
        rd(8'h39, 8'hA3);
        wr(8'h35, 8'hFF);
        rd(8'h35, 8'h3F);
        wr(8'h36, 8'hFF);
        @(negedge ref_clk_i);
        chk("ratio max", 16'h3FFF, ratio_o);
        chk("auto flag", 1'b0, auto_o);
        wr(8'h35, 8'h01);
        wr(8'h36, 8'h02);
        @(negedge ref_clk_i);
        chk("ratio split", 16'h0102, ratio_o);
        wr(8'h35, 8'h00);
        wr(8'h36, 8'h00);
        chk("auto flag", 1'b1, auto_o);
        repeat (300) @(negedge ref_clk_i);
        chk("detected ratio", 16'h0008, ratio_o);
        rd(8'h71, 8'h08);
        rd(8'h70, 8'h80);
        wr(8'h38, 8'h80);
        chk("target bit clock", 1'b0, pbclk_oe_o);
        frame(8'h80, 8'h04, 32);
        frame(8'h81, 8'h00, 2048);
        frame(8'h00, 8'h04, 24);
        frame(8'h40, 8'h04, 24);
        frame(8'hC0, 8'h04, 32);
        stop_test;
    end
endmodule : tb_top
